/* File: hw/energy_pkg.sv */
package energy_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int PROD_W = 2 * SAMPLE_W + 1;
  localparam int TOT_W = PROD_W + 3;
  localparam int ACC_W = 41;
  localparam int ENERGY_W = 16;
  localparam int DIV_W = 12;
  localparam int TARGET_W = 16;
  localparam int PERIOD_W = 16;
  localparam int REG_W = 16;
  localparam int CNT_W = 24;
  localparam int DFC_W = 50;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CM_ACCUM_INPUT_SELECT_LSB = 0;
  localparam int CM_SUM_LSB = 2;
  localparam int CM_ABS_BIT = 5;
  localparam int LC_ON_BIT = 0;
  localparam int LC_ZX_LSB = 3;
  localparam int LC_CLR_BIT = 6;
  localparam int MM_FREQ_LSB = 0;
  localparam int ST_DONE_BIT = 12;
  localparam logic [1:0] ACCUM_INPUT_SELECT_RSVD = 2'h3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] COMPUTE_RST = 8'h1C;
  localparam logic [7:0] LINE_CFG_RST = 8'h38;
  localparam logic [7:0] MEASURE_RST = 8'h00;
  localparam logic [REG_W-1:0] MASK_RST = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
  localparam logic [TARGET_W-1:0] TARGET_RST = 16'hFFFF;

  // ---------------------------------------------------------------
  // Filter and timing
  // ---------------------------------------------------------------
  localparam int LPF_SHIFT = 8;
  localparam int COMP_SHIFT = 12;
  localparam logic [PERIOD_W-1:0] NOMINAL_PERIOD = 16'h2000;
  localparam longint CLK_HZ = 40_000_000;
  localparam longint SAMPLE_HZ = CLK_HZ / 4;
  localparam longint MAX_PULSE_HZ = 16_000;
  localparam longint FULL_SCALE_AVG = 536_870_912;
  localparam logic [47:0] DFC_THRESH =
    48'(FULL_SCALE_AVG * SAMPLE_HZ / MAX_PULSE_HZ);
  localparam logic [CNT_W-1:0] EQUAL_WIDTH_CYC = 24'h00_0040;
  localparam longint LONG_PERIOD_MS = 180;
  localparam longint FIXED_WIDTH_MS = 90;
  localparam logic [CNT_W-1:0] LONG_PERIOD_CYC =
    24'(LONG_PERIOD_MS * CLK_HZ / 1000);
  localparam logic [CNT_W-1:0] FIXED_WIDTH_CYC =
    24'(FIXED_WIDTH_MS * CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_COMPUTE, SEL_LINE_CFG, SEL_MEASURE, SEL_MASK, SEL_STATUS,
    SEL_NUM, SEL_DEN, SEL_TARGET, SEL_ENERGY_A, SEL_ENERGY_B,
    SEL_ENERGY_C, SEL_VAR_A, SEL_VAR_B, SEL_VAR_C
  } reg_sel_t;
  localparam int NUM_SEL = 14;

  typedef struct packed {
    logic wr;
    logic rd;
    reg_sel_t sel;
    logic [REG_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] volt;
    logic signed [SAMPLE_W-1:0] cur;
    logic signed [SAMPLE_W-1:0] cur_shift;
  } phase_sample_t;

endpackage

/* File: hw/energy_pulse_and_line_cycle_accum.sv */
`timescale 1ns/1ps
`default_nettype none
module energy_pulse_and_line_cycle_accum #(
  parameter logic [23:0] LONG_PERIOD_CYCLES = energy_pkg::LONG_PERIOD_CYC,
  parameter logic [23:0] FIXED_WIDTH_CYCLES = energy_pkg::FIXED_WIDTH_CYC,
  parameter logic [47:0] DFC_THRESHOLD = energy_pkg::DFC_THRESH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire energy_pkg::phase_sample_t phase_in [3],
  input wire logic [2:0] zero_cross,
  input wire logic [energy_pkg::PERIOD_W-1:0] line_period [3],
  input wire logic integrator_on,
  input wire energy_pkg::reg_req_t reg_req,
  output logic [energy_pkg::REG_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic active_pulse_out,
  output logic irq_n
);
  import energy_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic signed [SAMPLE_W:0] pick_cur(
    input logic [1:0] cs,
    input int ph,
    input logic signed [SAMPLE_W-1:0] a,
    input logic signed [SAMPLE_W-1:0] b,
    input logic signed [SAMPLE_W-1:0] c
  );
    logic signed [SAMPLE_W:0] r;
    r = '0;
    if (cs != ACCUM_INPUT_SELECT_RSVD) begin
      if (ph == 0) begin
        if (cs == 2'h0) r = {a[SAMPLE_W-1], a};
        else r = {a[SAMPLE_W-1], a} - {b[SAMPLE_W-1], b};
      end else if (ph == 1) begin
        if (cs == 2'h0) r = {b[SAMPLE_W-1], b};
      end else begin
        if (cs == 2'h1) r = {c[SAMPLE_W-1], c} - {b[SAMPLE_W-1], b};
        else r = {c[SAMPLE_W-1], c};
      end
    end
    return r;
  endfunction

  function automatic logic signed [PROD_W-1:0] lpf_step(
    input logic signed [PROD_W-1:0] avg,
    input logic signed [PROD_W-1:0] x
  );
    logic signed [PROD_W:0] d;
    d = {x[PROD_W-1], x} - {avg[PROD_W-1], avg};
    d = d >>> LPF_SHIFT;
    return avg + d[PROD_W-1:0];
  endfunction

  function automatic logic signed [ACC_W-1:0] widen(
    input logic signed [PROD_W-1:0] x
  );
    return {{(ACC_W - PROD_W){x[PROD_W-1]}}, x};
  endfunction

  function automatic logic signed [TOT_W-1:0] term(
    input logic signed [PROD_W-1:0] x,
    input logic en,
    input logic mag
  );
    logic signed [TOT_W-1:0] t;
    t = {{(TOT_W - PROD_W){x[PROD_W-1]}}, x};
    if (!en) t = '0;
    else if (mag && x[PROD_W-1]) t = -t;
    return t;
  endfunction

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] compute_mode_reg, line_cycle_cfg, measure_mode_reg;
  logic [REG_W-1:0] irq_mask;
  logic [DIV_W-1:0] pulse_divider_numerator, pulse_divider_denominator;
  logic [TARGET_W-1:0] half_cycle_target;
  logic cycle_done_flag;

  wire wr_en = reg_req.wr;
  wire rd_en = reg_req.rd;
  wire wr_target = wr_en && reg_req.sel == SEL_TARGET;
  wire rd_status = rd_en && reg_req.sel == SEL_STATUS;

  wire [1:0] accum_input_select = compute_mode_reg[CM_ACCUM_INPUT_SELECT_LSB +: 2];
  wire [2:0] phase_sum_select = compute_mode_reg[CM_SUM_LSB +: 3];
  wire absolute_only = compute_mode_reg[CM_ABS_BIT];
  wire line_cycle_energy_on = line_cycle_cfg[LC_ON_BIT];
  wire [2:0] crossing_phase_pick = line_cycle_cfg[LC_ZX_LSB +: 3];
  wire clear_on_read = line_cycle_cfg[LC_CLR_BIT];
  wire [1:0] freq_source_pick = measure_mode_reg[MM_FREQ_LSB +: 2];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      compute_mode_reg <= COMPUTE_RST;
      line_cycle_cfg <= LINE_CFG_RST;
      measure_mode_reg <= MEASURE_RST;
      irq_mask <= MASK_RST;
      pulse_divider_numerator <= DIV_RST;
      pulse_divider_denominator <= DIV_RST;
      half_cycle_target <= TARGET_RST;
    end else if (wr_en) begin
      if (reg_req.sel == SEL_COMPUTE) compute_mode_reg <= reg_req.wdata[7:0];
      if (reg_req.sel == SEL_LINE_CFG) line_cycle_cfg <= reg_req.wdata[7:0];
      if (reg_req.sel == SEL_MEASURE) measure_mode_reg <= reg_req.wdata[7:0];
      if (reg_req.sel == SEL_MASK) irq_mask <= reg_req.wdata;
      if (reg_req.sel == SEL_NUM)
        pulse_divider_numerator <= reg_req.wdata[DIV_W-1:0];
      if (reg_req.sel == SEL_DEN)
        pulse_divider_denominator <= reg_req.wdata[DIV_W-1:0];
      if (wr_target) half_cycle_target <= reg_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Per-phase power and energy
  // ---------------------------------------------------------------
  logic signed [PROD_W-1:0] p_avg [3];
  logic signed [PROD_W-1:0] q_avg [3];
  logic signed [ACC_W-1:0] w_acc [3];
  logic signed [ACC_W-1:0] lc_acc [3];
  logic signed [ACC_W-1:0] v_acc [3];
  logic [ENERGY_W-1:0] lc_latch [3];
  logic [ENERGY_W-1:0] phase_energy [3];
  logic [ENERGY_W-1:0] var_energy [3];
  logic [2:0] clr_wh, clr_varh;
  logic lc_restart, lc_done;

  wire [1:0] freq_idx =
    (freq_source_pick == 2'h3) ? 2'h0 : freq_source_pick;
  wire signed [PERIOD_W:0] period_dev =
    {1'b0, line_period[freq_idx]} - {1'b0, NOMINAL_PERIOD};

  assign clr_wh[0] = clear_on_read && rd_en && reg_req.sel == SEL_ENERGY_A;
  assign clr_wh[1] = clear_on_read && rd_en && reg_req.sel == SEL_ENERGY_B;
  assign clr_wh[2] = clear_on_read && rd_en && reg_req.sel == SEL_ENERGY_C;
  assign clr_varh[0] = clear_on_read && rd_en && reg_req.sel == SEL_VAR_A;
  assign clr_varh[1] = clear_on_read && rd_en && reg_req.sel == SEL_VAR_B;
  assign clr_varh[2] = clear_on_read && rd_en && reg_req.sel == SEL_VAR_C;

  for (genvar g = 0; g < 3; g++) begin : g_phase
    wire signed [SAMPLE_W:0] cur_p = pick_cur(accum_input_select, g,
      phase_in[0].cur, phase_in[1].cur, phase_in[2].cur);
    wire signed [SAMPLE_W:0] cur_q_raw = pick_cur(accum_input_select, g,
      phase_in[0].cur_shift, phase_in[1].cur_shift, phase_in[2].cur_shift);
    wire signed [SAMPLE_W:0] cur_q = integrator_on ? -cur_q_raw : cur_q_raw;
    wire signed [PROD_W-1:0] p_prod = phase_in[g].volt * cur_p;
    wire signed [PROD_W-1:0] q_prod = phase_in[g].volt * cur_q;
    wire signed [PROD_W+PERIOD_W:0] q_scale = q_avg[g] * period_dev;
    wire signed [PROD_W+PERIOD_W:0] q_adj = q_scale >>> COMP_SHIFT;
    wire signed [PROD_W-1:0] q_comp = q_avg[g] + q_adj[PROD_W-1:0];

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        p_avg[g] <= '0;
        q_avg[g] <= '0;
      end else if (sample_valid) begin
        p_avg[g] <= lpf_step(p_avg[g], p_prod);
        q_avg[g] <= lpf_step(q_avg[g], q_prod);
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        w_acc[g] <= '0;
        v_acc[g] <= '0;
      end else begin
        if (clr_wh[g]) w_acc[g] <= '0;
        else if (sample_valid) w_acc[g] <= w_acc[g] + widen(p_avg[g]);
        if (clr_varh[g]) v_acc[g] <= '0;
        else if (sample_valid) v_acc[g] <= v_acc[g] + widen(q_comp);
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        lc_acc[g] <= '0;
        lc_latch[g] <= '0;
      end else begin
        if (lc_restart || lc_done) lc_acc[g] <= '0;
        else if (sample_valid) lc_acc[g] <= lc_acc[g] + widen(p_avg[g]);
        if (lc_done) lc_latch[g] <= lc_acc[g][ACC_W-1 -: ENERGY_W];
      end
    end

    assign phase_energy[g] = line_cycle_energy_on ? lc_latch[g] :
      w_acc[g][ACC_W-1 -: ENERGY_W];
    assign var_energy[g] = v_acc[g][ACC_W-1 -: ENERGY_W];
  end

  // ---------------------------------------------------------------
  // Zero-crossing counter
  // ---------------------------------------------------------------
  logic [TARGET_W-1:0] zx_cnt;
  wire [2:0] zx_hits = zero_cross & crossing_phase_pick;
  wire [1:0] zx_inc =
    {1'b0, zx_hits[0]} + {1'b0, zx_hits[1]} + {1'b0, zx_hits[2]};
  wire [TARGET_W:0] zx_sum = {1'b0, zx_cnt} + {15'h0000, zx_inc};
  wire [TARGET_W-1:0] eff_target =
    (half_cycle_target == '0) ? 16'h0001 : half_cycle_target;
  wire lc_hit = (zx_inc != 2'h0) && (zx_sum >= {1'b0, eff_target});

  assign lc_restart = wr_target && line_cycle_energy_on;
  assign lc_done = lc_hit && line_cycle_energy_on && !lc_restart;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) zx_cnt <= '0;
    else if (lc_restart || lc_hit) zx_cnt <= '0;
    else zx_cnt <= zx_sum[TARGET_W-1:0];
  end

  // ---------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------
  // done flag, set wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) cycle_done_flag <= 1'b0;
    else if (lc_done) cycle_done_flag <= 1'b1;
    else if (rd_status) cycle_done_flag <= 1'b0;
  end

  wire [REG_W-1:0] status_word = REG_W'({cycle_done_flag}) << ST_DONE_BIT;
  assign irq_n = ~|(status_word & irq_mask);

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [REG_W-1:0] rd_table [NUM_SEL];
  assign rd_table[SEL_COMPUTE] = {8'h00, compute_mode_reg};
  assign rd_table[SEL_LINE_CFG] = {8'h00, line_cycle_cfg};
  assign rd_table[SEL_MEASURE] = {8'h00, measure_mode_reg};
  assign rd_table[SEL_MASK] = irq_mask;
  assign rd_table[SEL_STATUS] = status_word;
  assign rd_table[SEL_NUM] = {4'h0, pulse_divider_numerator};
  assign rd_table[SEL_DEN] = {4'h0, pulse_divider_denominator};
  assign rd_table[SEL_TARGET] = half_cycle_target;
  assign rd_table[SEL_ENERGY_A] = phase_energy[0];
  assign rd_table[SEL_ENERGY_B] = phase_energy[1];
  assign rd_table[SEL_ENERGY_C] = phase_energy[2];
  assign rd_table[SEL_VAR_A] = var_energy[0];
  assign rd_table[SEL_VAR_B] = var_energy[1];
  assign rd_table[SEL_VAR_C] = var_energy[2];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_en;
      if (rd_en) reg_rdata <= rd_table[reg_req.sel];
    end
  end

  // ---------------------------------------------------------------
  // Digital-to-frequency converter
  // ---------------------------------------------------------------
  logic signed [DFC_W-1:0] dfc_acc;
  logic dfc_pulse;
  wire signed [TOT_W-1:0] total_power =
    term(p_avg[0], phase_sum_select[0], absolute_only) +
    term(p_avg[1], phase_sum_select[1], absolute_only) +
    term(p_avg[2], phase_sum_select[2], absolute_only);
  wire signed [DFC_W-1:0] thr = {2'b00, DFC_THRESHOLD};
  wire signed [DFC_W-1:0] dfc_sum =
    dfc_acc + {{(DFC_W - TOT_W){total_power[TOT_W-1]}}, total_power};
  wire dfc_pos = dfc_sum >= thr;
  wire dfc_neg = dfc_sum <= -thr;
  wire signed [DFC_W-1:0] next_dfc = dfc_pos ? dfc_sum - thr :
    dfc_neg ? dfc_sum + thr : dfc_sum;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dfc_acc <= '0;
      dfc_pulse <= 1'b0;
    end else begin
      dfc_pulse <= sample_valid && (dfc_pos || dfc_neg);
      if (sample_valid) dfc_acc <= next_dfc;
    end
  end

  pulse_shaper #(
    .LONG_PERIOD_CYCLES(LONG_PERIOD_CYCLES),
    .FIXED_WIDTH_CYCLES(FIXED_WIDTH_CYCLES)
  ) u_shaper (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .dfc_pulse(dfc_pulse),
    .div_num(pulse_divider_numerator),
    .div_den(pulse_divider_denominator),
    .active_pulse_out(active_pulse_out)
  );
endmodule
`default_nettype wire

/* File: hw/pulse_shaper.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_shaper #(
  parameter logic [23:0] LONG_PERIOD_CYCLES = energy_pkg::LONG_PERIOD_CYC,
  parameter logic [23:0] FIXED_WIDTH_CYCLES = energy_pkg::FIXED_WIDTH_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dfc_pulse,
  input wire logic [energy_pkg::DIV_W-1:0] div_num,
  input wire logic [energy_pkg::DIV_W-1:0] div_den,
  output logic active_pulse_out
);
  import energy_pkg::*;

  logic [DIV_W:0] frac;
  logic [CNT_W-1:0] dfc_cnt, dfc_period, out_cnt, width_cnt;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // zero reads as one
  wire [DIV_W-1:0] num_eff = (div_num == '0) ? 12'h001 : div_num;
  wire [DIV_W-1:0] den_eff = (div_den == '0) ? 12'h001 : div_den;
  wire [DIV_W:0] frac_sum = frac + {1'b0, num_eff};
  wire fire = dfc_pulse && (frac_sum >= {1'b0, den_eff});
  wire [DIV_W:0] frac_left = frac_sum - {1'b0, den_eff};
  wire [DIV_W:0] next_frac = !dfc_pulse ? frac :
    !fire ? frac_sum :
    (frac_left >= {1'b0, den_eff}) ? '0 : frac_left;

  // ---------------------------------------------------------------
  // Width selection
  // ---------------------------------------------------------------
  wire [DIV_W-1:0] half_den = DIV_W'(({1'b0, den_eff} + 13'h0001) >> 1);
  wire [CNT_W+DIV_W-1:0] prop_full = dfc_period * half_den;
  wire [CNT_W-1:0] prop_sat =
    (prop_full[CNT_W+DIV_W-1:CNT_W] != '0) ? '1 : prop_full[CNT_W-1:0];
  wire [CNT_W-1:0] half_period = out_cnt >> 1;
  wire [CNT_W-1:0] prop_cap =
    (prop_sat > half_period) ? half_period : prop_sat;
  wire [CNT_W-1:0] next_width =
    (out_cnt > LONG_PERIOD_CYCLES) ? FIXED_WIDTH_CYCLES :
    (num_eff == den_eff) ? EQUAL_WIDTH_CYC :
    (den_eff > num_eff && prop_cap != '0) ? prop_cap : EQUAL_WIDTH_CYC;

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frac <= '0;
      dfc_cnt <= '0;
      dfc_period <= '0;
    end else begin
      frac <= next_frac;
      if (dfc_pulse) begin
        dfc_period <= dfc_cnt;
        dfc_cnt <= '0;
      end else if (dfc_cnt != '1) begin
        dfc_cnt <= dfc_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_cnt <= '0;
      width_cnt <= '0;
      active_pulse_out <= 1'b0;
    end else begin
      if (fire) begin
        out_cnt <= '0;
        width_cnt <= next_width;
      end else begin
        if (out_cnt != '1) out_cnt <= out_cnt + 1'b1;
        if (width_cnt != '0) width_cnt <= width_cnt - 1'b1;
      end
      active_pulse_out <= fire || (width_cnt > 24'h00_0001);
    end
  end
endmodule
`default_nettype wire

/* File: test/cal_meter.sv */
`timescale 1ns/1ps
`default_nettype none
module cal_meter (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pulse_in,
  output var int pulse_count,
  output var int last_width
);
  int run_len;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pulse_count <= 0;
      last_width <= 0;
      run_len <= 0;
    end else if (pulse_in) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_width <= run_len;
      pulse_count <= pulse_count + 1;
      run_len <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: test/energy_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module energy_asserts #(
  parameter logic [23:0] LONG_PERIOD_CYCLES = 24'h00_07D0,
  parameter logic [23:0] FIXED_WIDTH_CYCLES = 24'h00_03E8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire energy_pkg::reg_req_t reg_req,
  input wire logic [energy_pkg::REG_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic active_pulse_out,
  input wire logic irq_n
);
  import energy_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------
  // Shadows
  // ------
  logic mask_on;
  logic [11:0] num_q;
  logic [11:0] den_q;
  logic [23:0] high_len;
  logic was_high;
  logic [23:0] since_rise;
  logic [23:0] span;
  wire logic wr_mask = reg_req.wr && reg_req.sel == SEL_MASK;
  wire logic wr_num = reg_req.wr && reg_req.sel == SEL_NUM;
  wire logic wr_den = reg_req.wr && reg_req.sel == SEL_DEN;
  wire logic rd_stat = reg_req.rd && reg_req.sel == SEL_STATUS;
  wire logic div_eq = (num_q | 12'(num_q == 0)) == (den_q | 12'(den_q == 0));
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_on <= 1'h0;
      num_q <= 12'h000;
      den_q <= 12'h000;
      high_len <= 24'h00_0000;
      was_high <= 1'h0;
      since_rise <= 24'h00_0000;
      span <= 24'h00_0000;
    end else begin
      was_high <= active_pulse_out;
      // Rise-to-rise distance mirrors the period the shaper measured
      if (active_pulse_out && !was_high) begin
        span <= since_rise;
        since_rise <= 24'h00_0000;
      end else if (since_rise != 24'hFF_FFFF) begin
        since_rise <= since_rise + 24'h00_0001;
      end
      if (wr_mask) mask_on <= reg_req.wdata[ST_DONE_BIT];
      if (wr_num) num_q <= reg_req.wdata[11:0];
      if (wr_den) den_q <= reg_req.wdata[11:0];
      high_len <= active_pulse_out ? high_len + 24'h00_0001 : 24'h00_0000;
    end
  end
  // ------
  // Properties
  // ------
  reset_quiet_a: assert property (
    disable iff (1'b0) !rst_n |=> irq_n && !active_pulse_out && !reg_rvalid)
    else $error("outputs not idle after reset");
  rvalid_timing_a: assert property (
    reg_req.rd |=> reg_rvalid) else $error("read not answered");
  rvalid_cause_a: assert property (
    reg_rvalid |-> $past(reg_req.rd)) else $error("answer without read");
  rdata_hold_a: assert property (
    !$past(reg_req.rd) |-> $stable(reg_rdata)) else $error("read data moved");
  div_upper_a: assert property (
    reg_rvalid && $past(reg_req.sel) inside {SEL_NUM, SEL_DEN}
    |-> reg_rdata[15:12] == 4'h0) else $error("divider upper bits set");
  cfg_upper_a: assert property (
    reg_rvalid && $past(reg_req.sel) inside {SEL_COMPUTE, SEL_LINE_CFG}
    |-> reg_rdata[15:8] == 8'h00) else $error("config upper bits set");
  irq_mask_a: assert property (
    !mask_on |-> irq_n) else $error("interrupt while masked");
  irq_release_a: assert property (
    $rose(irq_n) |-> $past(rd_stat) || $past(wr_mask) || !$past(rst_n))
    else $error("interrupt released without cause");
  pulse_width_a: assert property (
    $fell(active_pulse_out) && $past(rst_n) && div_eq
    |-> ((span > LONG_PERIOD_CYCLES) ?
      (high_len >= EQUAL_WIDTH_CYC && high_len <= FIXED_WIDTH_CYCLES) :
      (high_len == EQUAL_WIDTH_CYC)))
    else $error("equal divider pulse width wrong");
  cover property ($rose(active_pulse_out));
  cover property ($fell(irq_n));
  cover property (reg_rvalid && reg_rdata[ST_DONE_BIT]);
endmodule
bind energy_pulse_and_line_cycle_accum energy_asserts #(
  .LONG_PERIOD_CYCLES(LONG_PERIOD_CYCLES),
  .FIXED_WIDTH_CYCLES(FIXED_WIDTH_CYCLES)
) u_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .active_pulse_out(active_pulse_out),
  .irq_n(irq_n)
);
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import energy_pkg::*;
  localparam int LONG_C = 32'h0000_07D0;
  localparam int FIX_C = 32'h0000_03E8;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic sample_valid = 0;
  logic integrator_on = 0;
  logic [2:0] zero_cross = 0;
  phase_sample_t phase_in [3];
  logic [PERIOD_W-1:0] line_period [3];
  reg_req_t reg_req = '0;
  logic [REG_W-1:0] reg_rdata;
  logic reg_rvalid, active_pulse_out, irq_n;
  logic [15:0] v;
  int fail_count = 0, comparisons = 0, cyc = 0, cnt, wid, n, base, per;
  int seed = 32'he31f_38bf;
  reg_sel_t rs [8] = '{SEL_COMPUTE, SEL_LINE_CFG, SEL_MEASURE, SEL_MASK,
    SEL_NUM, SEL_DEN, SEL_TARGET, SEL_STATUS};
  logic [15:0] rv [8] = '{16'(COMPUTE_RST), 16'(LINE_CFG_RST),
    16'(MEASURE_RST), MASK_RST, 16'(DIV_RST), 16'(DIV_RST), TARGET_RST, 16'h0};
  logic [7:0] cm [4] = '{8'h0C, 8'h2C, 8'h10, 8'h04};
  always #12.5 sys_clk = ~sys_clk;
  energy_pulse_and_line_cycle_accum #(.LONG_PERIOD_CYCLES(24'(LONG_C)),
    .FIXED_WIDTH_CYCLES(24'(FIX_C)), .DFC_THRESHOLD(48'h000C_8000_0000)
  ) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .phase_in(phase_in), .zero_cross(zero_cross), .line_period(line_period),
    .integrator_on(integrator_on), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .active_pulse_out(active_pulse_out),
    .irq_n(irq_n));
  cal_meter u_meter (.sys_clk(sys_clk), .rst_n(rst_n),
    .pulse_in(active_pulse_out), .pulse_count(cnt), .last_width(wid));
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 32'h0001_5F90) begin
      fail_count++;
      close_out();
    end
    #2 sample_valid = (cyc % 4 == 0);
  end
  // ------
  // Tasks
  // ------
  task automatic close_out();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  task automatic reg_wr(input reg_sel_t s, input logic [15:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    tick(1);
    reg_req.wr = 0;
    tick(1);
  endtask
  task automatic reg_rd(input reg_sel_t s, output logic [15:0] d);
    reg_req = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 16'h0};
    tick(1);
    reg_req.rd = 0;
    check_val({15'h0, reg_rvalid}, 16'h0001);
    d = reg_rdata;
    tick(1);
  endtask
  task automatic zx(input logic [2:0] p);
    zero_cross = p;
    tick(1);
    zero_cross = 0;
    tick(1);
  endtask
  function automatic int exp_width(input int den, input int p);
    if (den * p > LONG_C)
      return FIX_C;
    return ((den + 1) / 2) * p;
  endfunction
  // ------
  // Sequence
  // ------
  initial begin
    for (int i = 0; i < 3; i++) begin
      phase_in[i] = '0;
      line_period[i] = NOMINAL_PERIOD;
    end
    tick(4);
    rst_n = 1;
    for (int i = 0; i < 8; i++) begin
      reg_rd(rs[i], v);
      check_val(v, rv[i]);
    end
    for (int i = 4; i < 7; i++) begin
      n = $random(seed);
      reg_wr(rs[i], n[15:0]);
      reg_rd(rs[i], v);
      check_val(v, i == 6 ? n[15:0] : {4'h0, n[11:0]});
    end
    reg_wr(SEL_STATUS, 16'hFFFF);
    reg_rd(SEL_STATUS, v);
    check_val(v, 16'h0000);
    reg_wr(SEL_NUM, 16'h0000);
    reg_wr(SEL_DEN, 16'h0000);
    reg_wr(SEL_MASK, 16'h1000);
    reg_wr(SEL_TARGET, 16'hFFFF);
    reg_wr(SEL_LINE_CFG, 16'h0009);
    repeat (3) zx(3'b001);
    n = 2 + ($random(seed) & 3);
    reg_wr(SEL_TARGET, 16'(n));
    for (int i = 0; i < n; i++) begin
      check_val({15'h0, irq_n}, 16'h0001);
      zx(3'b110);
      zx(3'b001);
    end
    check_val({15'h0, irq_n}, 16'h0000);
    reg_rd(SEL_STATUS, v);
    check_val(v & 16'h1000, 16'h1000);
    check_val({15'h0, irq_n}, 16'h0001);
    integrator_on = 1'($random(seed));
    phase_in[0] = '{16'h7FFF, 16'h7FFF, 16'h0000};
    phase_in[1] = '{16'h7FFF, 16'h8001, 16'h0000};
    tick(6000);
    for (int i = 0; i < 4; i++) begin
      reg_wr(SEL_COMPUTE, {8'h00, cm[i]});
      tick(1500);
      base = cnt;
      tick(3000);
      n = cnt - base;
      check_range(n, i % 2 ? 2 : 0, i % 2 ? 400 : 0);
    end
    per = 3000 / n;
    check_range(wid, 64, 64);
    reg_wr(SEL_NUM, 16'h0001);
    reg_wr(SEL_DEN, 16'h0004);
    tick(3000);
    base = cnt;
    tick(8000);
    n = 8000 / (4 * per);
    check_range(cnt - base, n - 1, n + 1);
    n = exp_width(4, per);
    check_range(wid, n - per / 4, n + per / 4);
    reg_wr(SEL_DEN, 16'h000C);
    tick(36 * per);
    check_range(wid, exp_width(12, per), exp_width(12, per));
    // Clear-on-read: second read sees at most one sample
    reg_wr(SEL_LINE_CFG, 16'h0040);
    reg_rd(SEL_ENERGY_A, v);
    reg_rd(SEL_ENERGY_A, v);
    check_range(v, 0, 32'h3FFF_0001 >> (ACC_W - ENERGY_W));
    close_out();
  end
endmodule
`default_nettype wire
